// >>> ccl_pulse_cfg.sv
// contact cleaning pulse configuration registers and pulse timer
// assumes an APB master on core_clk and a trigger from same-clock logic
`timescale 1ns/1ps

module ccl_pulse_cfg #(
  parameter int STEP_CYCLES = ccl_pkg::STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulseTrigger,
  output logic [23:0] pulseDrive,
  output logic [23:0] pulseCurrentHigh,
  output logic pulseBusy
);

  localparam int TICK_W = $clog2(STEP_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_CYCLES - 1);

  logic [23:0] timingQ;
  logic [23:0] enableQ;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [23:0] drive_q;
  logic [23:0] curHigh_q;
  logic busy_q;
  ccl_pkg::ccl_state_t state_q;
  logic [TICK_W-1:0] tick_q;
  logic [2:0] step_q;
  logic [2:0] dur_q;

  logic access;
  logic wrDone;
  logic mapped;
  logic [31:0] rdData;
  logic stepEnd;
  logic lastStep;
  logic start;
  logic [23:0] curHigh_d;

  assign access = psel & penable;
  assign wrDone = access & pready_q & pwrite;
  assign mapped = (paddr == ccl_pkg::ADDR_TIMING) ||
                  (paddr == ccl_pkg::ADDR_ENABLE) ||
                  (paddr == ccl_pkg::ADDR_STATUS);

  // ---------------- APB slave ----------------
  // one wait state so that read data comes from a flip-flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
    end
  end

  always_comb begin
    rdData = 32'h00000000;
    unique case (paddr)
      ccl_pkg::ADDR_TIMING: begin
        // upper bits never stored, so they read back as zero
        rdData = {8'h00, timingQ & ccl_pkg::TIMING_MASK};
      end
      ccl_pkg::ADDR_ENABLE: begin
        rdData = {8'h00, enableQ};
      end
      ccl_pkg::ADDR_STATUS: begin
        rdData[ccl_pkg::STAT_BUSY] = busy_q;
        rdData[ccl_pkg::STAT_STEP_LSB +: 3] = step_q;
        rdData[ccl_pkg::STAT_DUR_LSB +: 3] = dur_q;
      end
      default: begin
        rdData = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (access & ~pready_q) begin
      prdata_q <= pwrite ? 32'h00000000 : rdData;
      pslverr_q <= ~mapped;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timingQ <= ccl_pkg::TIMING_RST;
    end else if (wrDone && paddr == ccl_pkg::ADDR_TIMING) begin
      timingQ <= pwdata[23:0] & ccl_pkg::TIMING_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      enableQ <= ccl_pkg::ENABLE_RST;
    end else if (wrDone && paddr == ccl_pkg::ADDR_ENABLE) begin
      enableQ <= pwdata[23:0];
    end
  end

  // ---------------- pulse timer ----------------
  // a trigger while a pulse runs is ignored rather than queued
  assign start = (state_q == ccl_pkg::ST_IDLE) & pulseTrigger;
  assign stepEnd = (tick_q == TICK_LAST);
  assign lastStep = (step_q == dur_q);

  // each group of six inputs follows one select bit
  always_comb begin
    curHigh_d = 24'h000000;
    for (int i = 0; i < ccl_pkg::N_IN; i++) begin
      curHigh_d[i] = timingQ[ccl_pkg::SEL_LSB + i / ccl_pkg::GRP_SIZE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ccl_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        ccl_pkg::ST_IDLE: begin
          if (start) begin
            state_q <= ccl_pkg::ST_RUN;
          end
        end
        ccl_pkg::ST_RUN: begin
          if (stepEnd && lastStep) begin
            state_q <= ccl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= ccl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_q <= '0;
      step_q <= 3'h0;
    end else if (start || state_q != ccl_pkg::ST_RUN) begin
      tick_q <= '0;
      step_q <= 3'h0;
    end else if (stepEnd) begin
      tick_q <= '0;
      step_q <= step_q + 3'h1;
    end else begin
      tick_q <= tick_q + TICK_W'(1);
    end
  end

  // settings are sampled once per pulse; later writes wait for the next
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dur_q <= 3'h0;
      curHigh_q <= 24'h000000;
    end else if (start) begin
      dur_q <= timingQ[ccl_pkg::DUR_LSB +: ccl_pkg::DUR_W];
      curHigh_q <= curHigh_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_q <= 24'h000000;
      busy_q <= 1'b0;
    end else if (start) begin
      drive_q <= enableQ;
      busy_q <= 1'b1;
    end else if (state_q == ccl_pkg::ST_RUN && stepEnd && lastStep) begin
      drive_q <= 24'h000000;
      busy_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pulseDrive = drive_q;
  assign pulseCurrentHigh = curHigh_q;
  assign pulseBusy = busy_q;

  // ---------------- checks ----------------
  logic [19:0] runLen;
  logic [19:0] runWant;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      runLen <= 20'h00000;
    end else if (busy_q) begin
      runLen <= runLen + 20'h00001;
    end else begin
      runLen <= 20'h00000;
    end
  end

  assign runWant = 20'((32'(dur_q) + 32'd1) * 32'(STEP_CYCLES));

  property p_duration;
    @(posedge core_clk) disable iff (rst)
      $fell(busy_q) |-> runLen == runWant;
  endproperty
  a_duration: assert property (p_duration)
    else $error("pulse length does not match duration code");

  property p_dur_latch;
    @(posedge core_clk) disable iff (rst)
      $rose(busy_q) |-> dur_q == $past(timingQ[6:4]);
  endproperty
  a_dur_latch: assert property (p_dur_latch)
    else $error("duration code not taken at pulse start");

  sequence s_start;
    $rose(busy_q);
  endsequence

  property p_grp3;
    @(posedge core_clk) disable iff (rst)
      s_start |-> curHigh_q[23:18] == {6{$past(timingQ[3])}};
  endproperty
  a_grp3: assert property (p_grp3)
    else $error("inputs 18-23 current select wrong");

  property p_grp2;
    @(posedge core_clk) disable iff (rst)
      s_start |-> curHigh_q[17:12] == {6{$past(timingQ[2])}};
  endproperty
  a_grp2: assert property (p_grp2)
    else $error("inputs 12-17 current select wrong");

  property p_grp1;
    @(posedge core_clk) disable iff (rst)
      s_start |-> curHigh_q[11:6] == {6{$past(timingQ[1])}};
  endproperty
  a_grp1: assert property (p_grp1)
    else $error("inputs 6-11 current select wrong");

  property p_grp0;
    @(posedge core_clk) disable iff (rst)
      s_start |-> curHigh_q[5:0] == {6{$past(timingQ[0])}};
  endproperty
  a_grp0: assert property (p_grp0)
    else $error("inputs 0-5 current select wrong");

  property p_enable;
    @(posedge core_clk) disable iff (rst)
      s_start |-> drive_q == $past(enableQ);
  endproperty
  a_enable: assert property (p_enable)
    else $error("driven inputs differ from enable register");

  property p_idle_quiet;
    @(posedge core_clk) disable iff (rst)
      !busy_q |-> drive_q == 24'h000000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("pulse driven outside a pulse");

  property p_upper_zero;
    @(posedge core_clk) disable iff (rst)
      (access && pready_q && !pwrite && paddr == ccl_pkg::ADDR_TIMING)
        |-> prdata_q[31:7] == 25'h0000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("timing register upper bits not zero");

  property p_reset_zero;
    @(posedge core_clk)
      $past(rst) |-> timingQ == 24'h000000 && enableQ == 24'h000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("configuration not zero after reset");

  property p_enable_wr;
    @(posedge core_clk) disable iff (rst)
      wrDone && paddr == ccl_pkg::ADDR_ENABLE |=> enableQ == $past(pwdata[23:0]);
  endproperty
  a_enable_wr: assert property (p_enable_wr)
    else $error("enable register write lost");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
      busy_q && $past(busy_q) |-> $stable(drive_q) && $stable(curHigh_q) && $stable(dur_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pulse settings changed mid-pulse");

  property p_ready_one_wait;
    @(posedge core_clk) disable iff (rst)
      (access && !pready_q) |=> pready_q ##1 !pready_q;
  endproperty
  a_ready_one_wait: assert property (p_ready_one_wait)
    else $error("apb answer not after one wait state");

endmodule // ccl_pulse_cfg

// >>> ccl_pkg.sv
// constants for the contact cleaning pulse configuration block
// assumes a single 250 MHz core clock and an APB register port
package ccl_pkg;

  localparam int N_IN = 24;
  localparam int GRP_SIZE = 6;
  localparam int N_GRP = 4;
  localparam int REG_W = 24;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMING = 8'h1F;
  localparam logic [7:0] IDX_ENABLE = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h3F;
  localparam logic [11:0] ADDR_TIMING = {2'h0, IDX_TIMING, 2'h0};
  localparam logic [11:0] ADDR_ENABLE = {2'h0, IDX_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

  // timing register fields
  localparam int DUR_LSB = 4;
  localparam int DUR_W = 3;
  localparam int SEL_LSB = 0;
  localparam logic [23:0] TIMING_MASK = 24'h00007F;
  localparam logic [23:0] TIMING_RST = 24'h000000;
  localparam logic [23:0] ENABLE_RST = 24'h000000;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_STEP_LSB = 4;
  localparam int STAT_DUR_LSB = 8;

  // one duration step is 64 us; cycles derived from the clock rate
  localparam int STEP_US = 64;
  localparam int CLK_MHZ = 250;
  localparam int STEP_CYCLES = STEP_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } ccl_state_t;

endpackage

// >>> ccl_contact_model.sv
// behavioural load standing for the external switch contacts on the 24 inputs
// assumes drive and current select come from logic on the same core_clk
`timescale 1ns/1ps

module ccl_contact_model (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic [23:0] pulseDrive,
  input wire logic [23:0] pulseCurrentHigh,
  output int driveCycles,
  output logic [23:0] seenDrive,
  output logic [23:0] seenCurrent
);
  // a contact only notices cycles in which current actually flows
  always_ff @(posedge core_clk) begin
    if (clr) begin
      driveCycles <= 0;
      seenDrive <= 24'h000000;
      seenCurrent <= 24'h000000;
    end else if (pulseDrive !== 24'h000000) begin
      driveCycles <= driveCycles + 1;
      seenDrive <= pulseDrive;
      seenCurrent <= pulseCurrentHigh;
    end
  end
endmodule // ccl_contact_model

// >>> test_contact_cleaning_pulse_config.sv
// self-checking bench: APB register access and cleaning pulse runs
// assumes one wait state on APB and a shortened duration step
`timescale 1ns/1ps

module test_contact_cleaning_pulse_config;
  localparam int STEPS = 4;
  localparam int LIM = 5000;
  logic core_clk, rst, psel, penable, pwrite, pulseTrigger, clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, pulseBusy, e;
  logic [23:0] pulseDrive, pulseCurrentHigh, seenDrive, seenCurrent, en;
  logic [3:0] sel;
  int driveCycles, mismatches, checkCount;

  ccl_pulse_cfg #(.STEP_CYCLES(STEPS)) DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulseTrigger(pulseTrigger),
    .pulseDrive(pulseDrive), .pulseCurrentHigh(pulseCurrentHigh), .pulseBusy(pulseBusy));
  ccl_contact_model contacts (.core_clk(core_clk), .clr(clr), .pulseDrive(pulseDrive),
    .pulseCurrentHigh(pulseCurrentHigh), .driveCycles(driveCycles),
    .seenDrive(seenDrive), .seenCurrent(seenCurrent));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tmo(input int n);
    if (n >= LIM) begin
      mismatches++;
      summarize;
    end
  endtask

  // request held from setup until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < LIM);
    tmo(n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-raises psel in the same step
    @(posedge core_clk);
  endtask

  function automatic logic [23:0] expand(input logic [3:0] s);
    logic [23:0] v;
    for (int i = 0; i < 24; i++) v[i] = s[i / 6];
    return v;
  endfunction

  // mid: rewrite both registers and retrigger while the pulse runs
  task pulse(input logic [23:0] ex, input logic [23:0] cur, input int cyc, input bit mid);
    int n;
    clr <= 1'b1;
    pulseTrigger <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    pulseTrigger <= 1'b0;
    @(posedge core_clk);
    if (mid) begin
      apb(1'b1, ccl_pkg::ADDR_TIMING, 32'h00000000);
      apb(1'b1, ccl_pkg::ADDR_ENABLE, 32'h00000000);
      chk(pulseDrive, ex);
      apb(1'b0, ccl_pkg::ADDR_STATUS, 32'h00000000);
      chk(r & 32'h00000701, 32'h00000701);
      pulseTrigger <= 1'b1;
      @(posedge core_clk);
      pulseTrigger <= 1'b0;
    end
    n = 0;
    while (pulseBusy !== 1'b0 && n < LIM) begin
      @(posedge core_clk);
      n++;
    end
    tmo(n);
    @(posedge core_clk);
    chk(driveCycles, cyc);
    chk(seenDrive, ex);
    chk(pulseCurrentHigh, cur);
    chk(seenCurrent, cur);
    chk(pulseDrive, 24'h000000);
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pulseTrigger = 1'b0;
    clr = 1'b1;
    mismatches = 0;
    checkCount = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, ccl_pkg::ADDR_TIMING, 32'h00000000);
    chk(r, 32'h00000000);
    apb(1'b0, ccl_pkg::ADDR_ENABLE, 32'h00000000);
    chk(r, 32'h00000000);
    chk(e, 1'b0);
    apb(1'b1, ccl_pkg::ADDR_TIMING, 32'hFFFFFFFF);
    apb(1'b0, ccl_pkg::ADDR_TIMING, 32'h00000000);
    chk(r, 32'h0000007F);
    apb(1'b1, ccl_pkg::ADDR_ENABLE, 32'hFFFFFFFF);
    apb(1'b0, ccl_pkg::ADDR_ENABLE, 32'h00000000);
    chk(r, 32'h00FFFFFF);
    // unmapped word must error and read zero
    apb(1'b0, 12'h000, 32'h00000000);
    chk(e, 1'b1);
    chk(r, 32'h00000000);
    // every duration code, each current group bit both ways
    for (int c = 0; c < 8; c++) begin
      sel = 4'(c * 5);
      en = 24'h5A5A5A ^ 24'(c);
      apb(1'b1, ccl_pkg::ADDR_TIMING, {25'h0, 3'(c), sel});
      apb(1'b1, ccl_pkg::ADDR_ENABLE, {8'h00, en});
      pulse(en, expand(sel), (c + 1) * STEPS, 1'b0);
      apb(1'b0, ccl_pkg::ADDR_STATUS, 32'h00000000);
      chk(r, 32'(c) << 8);
    end
    // longest pulse with settings changed in mid-run
    apb(1'b1, ccl_pkg::ADDR_TIMING, 32'h0000007F);
    apb(1'b1, ccl_pkg::ADDR_ENABLE, 32'h00C3A5);
    pulse(24'h00C3A5, expand(4'hF), 8 * STEPS, 1'b1);
    pulse(24'h000000, expand(4'h0), 0, 1'b0);
    // reset while idle must clear registers that hold written values
    apb(1'b1, ccl_pkg::ADDR_TIMING, 32'h0000002A);
    apb(1'b1, ccl_pkg::ADDR_ENABLE, 32'h00ABCDEF);
    apb(1'b0, ccl_pkg::ADDR_ENABLE, 32'h00000000);
    chk(r, 32'h00ABCDEF);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, ccl_pkg::ADDR_TIMING, 32'h00000000);
    chk(r, 32'h00000000);
    apb(1'b0, ccl_pkg::ADDR_ENABLE, 32'h00000000);
    chk(r, 32'h00000000);
    summarize;
  end
endmodule // test_contact_cleaning_pulse_config
